/* core/sfpe_defines.svh */
`ifndef SFPE_DEFINES_SVH
`define SFPE_DEFINES_SVH

`define SFPE_CLK_MHZ      100
`define SFPE_HALF_DIV     4
`define SFPE_GAP_NS       50
`define SFPE_GAP_CYC      ((`SFPE_GAP_NS * `SFPE_CLK_MHZ + 999) / 1000)

`define SFPE_OFF_CMD      8'h00
`define SFPE_OFF_ADDR     8'h04
`define SFPE_OFF_LEN      8'h08
`define SFPE_OFF_DATA     8'h0C
`define SFPE_OFF_STS      8'h10
`define SFPE_OFF_CFG      8'h14

`define SFPE_STS_BUSY     0
`define SFPE_STS_REFUSED  1
`define SFPE_STS_INPROG   2
`define SFPE_STS_WRLAT    3
`define SFPE_STS_BYTE_LO  8
`define SFPE_CFG_QUAD     0
`define SFPE_CFG_POLL     1

`define SFPE_DEV_INPROG_BIT 0
`define SFPE_DEV_WRLAT_BIT  1

`define SFPE_CODE_WR_EN   8'h06
`define SFPE_CODE_PROG    8'h02
`define SFPE_CODE_QPP     8'h32
`define SFPE_CODE_FPROG   8'hF2
`define SFPE_CODE_SECT    8'h20
`define SFPE_CODE_BE32    8'h52
`define SFPE_CODE_BE64    8'hD8
`define SFPE_CODE_RDSR    8'h05

`define SFPE_PAGE_BYTES   9'h100
`define SFPE_HDR_BYTES    9'h004
`define SFPE_ERASE_LAST   9'h003
`define SFPE_POLL_LAST    9'h001
`define SFPE_OE_SINGLE    4'h2
`define SFPE_OE_QUAD      4'h0
`define SFPE_IDLE_LINES   4'hC
`define SFPE_HI_LINES     3'h6

`endif

/* core/sfpe_pkg.sv */
package sfpe_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_SHIFT = 3'h3,
    ST_HOLD  = 3'h2,
    ST_GAP   = 3'h6
  } sfpe_state_t;

  typedef enum logic [1:0] {
    PH_WR_EN = 2'h0,
    PH_CMD  = 2'h1,
    PH_POLL = 2'h3
  } sfpe_phase_t;

  typedef enum logic [2:0] {
    OP_WR_EN = 3'h0,
    OP_PROG  = 3'h1,
    OP_QPP   = 3'h2,
    OP_FPROG = 3'h3,
    OP_SECT  = 3'h4,
    OP_BE32 = 3'h5,
    OP_BE64 = 3'h6,
    OP_RDSR = 3'h7
  } sfpe_op_t;

  typedef struct packed {
    sfpe_state_t st;
    sfpe_phase_t ph;
    sfpe_op_t    op;
    logic [23:0] addr;
    logic [8:0]  len;
    logic [8:0]  wp;
    logic [8:0]  byte_i;
    logic [2:0]  bit_i;
    logic [7:0]  hc;
    logic        sck;
    logic        cs_n;
    logic [3:0]  dq_o;
    logic [3:0]  dq_oe_n;
    logic [3:0]  in_meta;
    logic [3:0]  in_sync;
    logic [7:0]  rx;
    logic [7:0]  stat;
    logic        busy;
    logic        refused;
    logic        quad_en;
    logic        apoll;
    logic        bus_wr;
    logic [7:0]  bus_a;
    logic [31:0] rdata;
    logic        resp;
  } sfpe_regs_t;

endpackage

/* core/sfpe_top.sv */
`timescale 1ns/1ns
`include "sfpe_defines.svh"

module sfpe_top
  import sfpe_pkg::*;
#(
  parameter int HALF_DIV = `SFPE_HALF_DIV,
  parameter int GAP_CYC  = `SFPE_GAP_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // serial flash pins
  output logic             CS_N,
  output logic             SCK,
  input  wire logic [3:0]  DATA_LINE_I,
  output logic      [3:0]  DATA_LINE_O,
  output logic      [3:0]  DATA_LINE_OE_N
);

  if (HALF_DIV < 1 || HALF_DIV > 256) begin : g_bad_half
    $error("HALF_DIV out of range");
  end
  if (GAP_CYC < 1 || GAP_CYC > 256) begin : g_bad_gap
    $error("GAP_CYC out of range");
  end

  localparam logic [7:0] HALF_LD = 8'(HALF_DIV - 1);
  localparam logic [7:0] GAP_LD  = 8'(GAP_CYC - 1);

  sfpe_regs_t s_q;
  sfpe_regs_t s_d;
  logic [7:0] page_mem [0:255];
  logic       buf_we;
  logic [7:0] buf_a;
  logic [7:0] buf_wd;
  logic       cmd_go;
  logic [7:0] code_now;
  logic [7:0] cur_byte;

  function automatic logic [7:0] opcode_of(sfpe_phase_t ph, sfpe_op_t op);
    logic [7:0] c;
    c = `SFPE_CODE_WR_EN;
    if (ph == PH_POLL) begin
      c = `SFPE_CODE_RDSR;
    end else if (ph == PH_CMD) begin
      unique case (op)
        OP_WR_EN: c = `SFPE_CODE_WR_EN;
        OP_PROG:  c = `SFPE_CODE_PROG;
        OP_QPP:   c = `SFPE_CODE_QPP;
        OP_FPROG: c = `SFPE_CODE_FPROG;
        OP_SECT:  c = `SFPE_CODE_SECT;
        OP_BE32: c = `SFPE_CODE_BE32;
        OP_BE64: c = `SFPE_CODE_BE64;
        OP_RDSR: c = `SFPE_CODE_RDSR;
      endcase
    end
    return c;
  endfunction

  // index of the byte after whose eighth bit chip select must rise
  function automatic logic [8:0] last_of(sfpe_phase_t ph, sfpe_op_t op, logic [8:0] len);
    logic [8:0] n;
    n = 9'h000;
    if (ph == PH_POLL) begin
      n = `SFPE_POLL_LAST;
    end else if (ph == PH_CMD) begin
      if (op == OP_PROG || op == OP_QPP || op == OP_FPROG) begin
        n = len + `SFPE_ERASE_LAST;
      end else if (op == OP_SECT || op == OP_BE32 || op == OP_BE64) begin
        n = `SFPE_ERASE_LAST;
      end
    end
    return n;
  endfunction

  function automatic sfpe_regs_t begin_frame(sfpe_regs_t r, sfpe_phase_t ph, logic [7:0] ld);
    sfpe_regs_t o;
    o        = r;
    o.ph     = ph;
    o.st     = ST_SETUP;
    o.cs_n   = 1'b0;
    o.sck    = 1'b0;
    o.hc     = ld;
    o.byte_i = 9'h000;
    o.bit_i  = 3'h0;
    return o;
  endfunction

  function automatic logic [7:0] byte_at(sfpe_regs_t r, logic [7:0] mem_byte);
    logic [7:0] b;
    unique case (r.byte_i)
      9'h000:  b = opcode_of(r.ph, r.op);
      9'h001:  b = r.addr[23:16];
      9'h002:  b = r.addr[15:8];
      9'h003:  b = r.addr[7:0];
      default: b = mem_byte;
    endcase
    return b;
  endfunction

  always_comb begin
    logic       wide;
    logic [3:0] nb;
    logic [8:0] mi;
    logic [2:0] bsel;
    logic       prog;
    logic       bad;
    sfpe_op_t   nop;
    s_d    = s_q;
    wide   = 1'b0;
    nb     = 4'h0;
    mi     = 9'h000;
    bsel   = 3'h0;
    prog   = 1'b0;
    bad    = 1'b0;
    nop    = OP_WR_EN;
    buf_we = 1'b0;
    buf_a  = s_q.wp[7:0];
    buf_wd = s_q.rdata[7:0];
    cmd_go = 1'b0;

    // pins from outside the clock domain pass two flops first
    s_d.in_meta = DATA_LINE_I;
    s_d.in_sync = s_q.in_meta;

    unique case (s_q.st)
      ST_IDLE: begin
      end
      ST_SETUP: begin
        if (s_q.hc != 8'h00) begin
          s_d.hc = s_q.hc - 8'h01;
        end else begin
          s_d.hc  = HALF_LD;
          s_d.sck = 1'b1;
          s_d.st  = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (s_q.hc != 8'h00) begin
          s_d.hc = s_q.hc - 8'h01;
        end else begin
          s_d.hc = HALF_LD;
          if (!s_q.sck) begin
            s_d.sck = 1'b1;
          end else begin
            s_d.sck = 1'b0;
            s_d.rx  = {s_q.rx[6:0], s_q.in_sync[1]};
            wide    = s_q.ph == PH_CMD && s_q.op == OP_QPP && s_q.byte_i >= `SFPE_HDR_BYTES;
            nb      = {1'b0, s_q.bit_i} + (wide ? 4'h4 : 4'h1);
            if (nb[3]) begin
              s_d.bit_i = 3'h0;
              if (s_q.byte_i == last_of(s_q.ph, s_q.op, s_q.len)) begin
                s_d.st = ST_HOLD;
              end else begin
                s_d.byte_i = s_q.byte_i + 9'h001;
              end
            end else begin
              s_d.bit_i = nb[2:0];
            end
          end
        end
      end
      ST_HOLD: begin
        // chip select held low one half period past the last falling edge
        if (s_q.hc != 8'h00) begin
          s_d.hc = s_q.hc - 8'h01;
        end else begin
          s_d.cs_n = 1'b1;
          s_d.st   = ST_GAP;
          s_d.hc   = GAP_LD;
        end
      end
      ST_GAP: begin
        if (s_q.hc != 8'h00) begin
          s_d.hc = s_q.hc - 8'h01;
        end else begin
          s_d.st = ST_IDLE;
          unique case (s_q.ph)
            PH_WR_EN: s_d = begin_frame(s_d, PH_CMD, HALF_LD);
            PH_CMD: begin
              if (s_q.apoll && s_q.op != OP_WR_EN) begin
                s_d = begin_frame(s_d, PH_POLL, HALF_LD);
              end else begin
                s_d.busy = 1'b0;
              end
            end
            PH_POLL: begin
              s_d.stat = s_q.rx;
              // polling after a program or erase keeps going while the device reports a cycle running
              if (s_q.rx[`SFPE_DEV_INPROG_BIT] && s_q.op != OP_RDSR) begin
                s_d = begin_frame(s_d, PH_POLL, HALF_LD);
              end else begin
                s_d.busy = 1'b0;
              end
            end
            default: s_d.busy = 1'b0;
          endcase
        end
      end
      default: begin
        s_d.st   = ST_IDLE;
        s_d.cs_n = 1'b1;
        s_d.sck  = 1'b0;
        s_d.busy = 1'b0;
      end
    endcase

    // ahb data phase of a write
    if (s_q.bus_wr) begin
      unique case (s_q.bus_a)
        `SFPE_OFF_CMD: begin
          nop    = sfpe_op_t'(HWDATA[2:0]);
          prog   = nop == OP_PROG || nop == OP_QPP || nop == OP_FPROG;
          bad    = s_q.busy;
          bad    = bad || (prog && (s_q.len == 9'h000 || s_q.len > `SFPE_PAGE_BYTES));
          bad    = bad || (nop == OP_QPP && !s_q.quad_en);
          bad    = bad || (prog && s_q.wp < s_q.len);
          s_d.refused = bad;
          if (!bad) begin
            cmd_go   = 1'b1;
            s_d.op   = nop;
            s_d.busy = 1'b1;
            if (nop == OP_RDSR) begin
              s_d = begin_frame(s_d, PH_POLL, HALF_LD);
            end else if (nop == OP_WR_EN) begin
              s_d = begin_frame(s_d, PH_CMD, HALF_LD);
            end else begin
              s_d = begin_frame(s_d, PH_WR_EN, HALF_LD);
            end
          end
        end
        `SFPE_OFF_ADDR: begin
          if (!s_q.busy) begin
            s_d.addr = HWDATA[23:0];
          end
        end
        `SFPE_OFF_LEN: begin
          if (!s_q.busy) begin
            s_d.len = HWDATA[8:0];
            s_d.wp  = 9'h000;
          end
        end
        `SFPE_OFF_DATA: begin
          // bytes written while busy or past one page are dropped and wp keeps its value
          if (!s_q.busy && s_q.wp < `SFPE_PAGE_BYTES) begin
            buf_we = 1'b1;
            buf_wd = HWDATA[7:0];
            s_d.wp = s_q.wp + 9'h001;
          end
        end
        `SFPE_OFF_CFG: begin
          s_d.quad_en = HWDATA[`SFPE_CFG_QUAD];
          s_d.apoll = HWDATA[`SFPE_CFG_POLL];
        end
        default: begin
        end
      endcase
    end

    // ahb address phase; zero wait states
    s_d.bus_wr = HSEL && HTRANS[1] && HREADY && HWRITE && HSIZE == 3'h2;
    s_d.bus_a  = HADDR[7:0];
    if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
      s_d.rdata = 32'h0000_0000;
      unique case (HADDR[7:0])
        `SFPE_OFF_CMD:  s_d.rdata[2:0] = s_q.op;
        `SFPE_OFF_ADDR: s_d.rdata[23:0] = s_q.addr;
        `SFPE_OFF_LEN:  s_d.rdata[8:0] = s_q.len;
        `SFPE_OFF_DATA: s_d.rdata[8:0] = s_q.wp;
        `SFPE_OFF_STS: begin
          s_d.rdata[`SFPE_STS_BUSY]    = s_q.busy;
          s_d.rdata[`SFPE_STS_REFUSED] = s_q.refused;
          s_d.rdata[`SFPE_STS_INPROG]  = s_q.stat[`SFPE_DEV_INPROG_BIT];
          s_d.rdata[`SFPE_STS_WRLAT]   = s_q.stat[`SFPE_DEV_WRLAT_BIT];
          s_d.rdata[`SFPE_STS_BYTE_LO +: 8] = s_q.stat;
        end
        `SFPE_OFF_CFG: begin
          s_d.rdata[`SFPE_CFG_QUAD] = s_q.quad_en;
          s_d.rdata[`SFPE_CFG_POLL] = s_q.apoll;
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    s_d.resp = 1'b0;

    // line drive follows the next state so pins and counters stay aligned
    mi   = s_d.byte_i - `SFPE_HDR_BYTES;
    wide = s_d.ph == PH_CMD && s_d.op == OP_QPP && s_d.byte_i >= `SFPE_HDR_BYTES;
    cur_byte = byte_at(s_d, page_mem[mi[7:0]]);
    bsel = 3'h7 - s_d.bit_i;
    if (s_d.cs_n) begin
      s_d.dq_o    = `SFPE_IDLE_LINES;
      s_d.dq_oe_n = `SFPE_OE_SINGLE;
    end else if (wide) begin
      s_d.dq_oe_n = `SFPE_OE_QUAD;
      s_d.dq_o    = (s_d.bit_i == 3'h0) ? cur_byte[7:4] : cur_byte[3:0];
    end else begin
      s_d.dq_oe_n = `SFPE_OE_SINGLE;
      s_d.dq_o    = {`SFPE_HI_LINES, cur_byte[bsel]};
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q         <= '0;
      s_q.st      <= ST_IDLE;
      s_q.cs_n    <= 1'b1;
      s_q.dq_o    <= `SFPE_IDLE_LINES;
      s_q.dq_oe_n <= `SFPE_OE_SINGLE;
    end else begin
      s_q <= s_d;
    end
  end

  // page buffer needs no reset; it is filled before every program
  always_ff @(posedge CLK) begin
    if (buf_we) begin
      page_mem[buf_a] <= buf_wd;
    end
  end

  assign HRDATA         = s_q.rdata;
  assign HREADYOUT      = 1'b1;
  assign HRESP          = s_q.resp;
  assign CS_N           = s_q.cs_n;
  assign SCK            = s_q.sck;
  assign DATA_LINE_O    = s_q.dq_o;
  assign DATA_LINE_OE_N = s_q.dq_oe_n;
  assign code_now       = opcode_of(s_q.ph, s_q.op);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_sck_in_frame: assert property ($rose(SCK) |-> !CS_N) else $error("clock edge outside frame");
  a_enable_lead: assert property ((cmd_go && s_d.op != OP_WR_EN && s_d.op != OP_RDSR) |=>
    (s_q.ph == PH_WR_EN && !CS_N)) else $error("program or erase without write enable");
  a_enable_then: assert property ((s_q.st == ST_GAP && s_q.hc == 8'h00 && s_q.ph == PH_WR_EN)
    |=> (s_q.ph == PH_CMD && s_q.st == ST_SETUP)) else $error("command did not follow enable");
  a_cs_rise_pos: assert property ($rose(CS_N) |-> (s_q.bit_i == 3'h0 &&
    s_q.byte_i == last_of(s_q.ph, s_q.op, s_q.len))) else $error("chip select rose mid byte");
  a_erase_len: assert property (($rose(CS_N) && s_q.ph == PH_CMD &&
    (s_q.op == OP_SECT || s_q.op == OP_BE32 || s_q.op == OP_BE64)) |->
    s_q.byte_i == `SFPE_ERASE_LAST) else $error("erase frame length wrong");
  a_quad_gate: assert property ((!CS_N && s_q.ph == PH_CMD && s_q.op == OP_QPP) |->
    s_q.quad_en) else $error("quad program without quad enable");
  a_first_bit: assert property ($fell(CS_N) |-> DATA_LINE_O[0] == code_now[7])
    else $error("opcode msb not first");
  a_rise_stable: assert property ($rose(SCK) |-> ($stable(DATA_LINE_O) &&
    $stable(DATA_LINE_OE_N))) else $error("lines moved at rising edge");
  a_hdr_single: assert property ((!CS_N && s_q.byte_i < `SFPE_HDR_BYTES) |->
    DATA_LINE_OE_N == `SFPE_OE_SINGLE) else $error("header not on single line");
  a_quad_data: assert property ((!CS_N && s_q.ph == PH_CMD && s_q.op == OP_QPP &&
    s_q.byte_i >= `SFPE_HDR_BYTES) |-> DATA_LINE_OE_N == `SFPE_OE_QUAD)
    else $error("quad data not on four lines");
  a_addr_msb: assert property ((SCK && !CS_N && s_q.ph == PH_CMD && s_q.byte_i == 9'h001 &&
    s_q.bit_i == 3'h0) |-> DATA_LINE_O[0] == s_q.addr[23]) else $error("address msb wrong");

  c_quad_done: cover property ($rose(CS_N) && s_q.ph == PH_CMD && s_q.op == OP_QPP);
  c_poll_again: cover property (s_q.st == ST_GAP && s_q.hc == 8'h00 && s_q.ph == PH_POLL &&
    s_q.rx[`SFPE_DEV_INPROG_BIT]);
  c_refused: cover property (s_q.bus_wr && s_q.bus_a == `SFPE_OFF_CMD && s_d.refused);
  c_erase_done: cover property ($rose(CS_N) && s_q.ph == PH_CMD && s_q.op == OP_BE64);

endmodule

/* testbench/sfpe_flash_model.sv */
`timescale 1ns/1ns

module sfpe_flash_model #(
  parameter int PROG_NS  = 3000,
  parameter int ERASE_NS = 6000,
  parameter bit QUAD_EN  = 1'b1,
  parameter bit PROT     = 1'b0
) (
  // serial pins as seen on the wires
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic [3:0]  lines,
  output logic             so,
  output logic             so_en,
  // record of the last executed operation, a count of executed operations and a count of status reads while busy
  output logic [7:0]       ev_op,
  output logic [23:0]      ev_addr,
  output logic [8:0]       ev_n,
  output logic [7:0]       ev_sum,
  output logic [7:0]       ev_cnt,
  output logic [7:0]       busy_polls
);
  logic [7:0]  op;
  logic [7:0]  acc;
  logic [23:0] addr;
  logic [7:0]  pg [256];
  logic        wr_latch;
  logic        in_prog;
  int          bits;
  int          nb;

  initial begin
    wr_latch = 1'b0;
    in_prog = 1'b0;
    so = 1'b1;
    so_en = 1'b0;
    ev_cnt = 8'h00;
    busy_polls = 8'h00;
  end

  always @(negedge cs_n) begin
    bits = 0;
    nb = 0;
    op = 8'h00;
    ev_sum = 8'h00;
    so_en = 1'b0;
  end

  // inputs taken on the rising serial clock, msb first
  always @(posedge sck) if (!cs_n) begin
    if (op == 8'h32 && bits >= 32 && QUAD_EN) begin
      acc = {acc[3:0], lines};
      bits += 4;
    end else begin
      acc = {acc[6:0], lines[0]};
      bits += 1;
    end
    if (bits % 8 == 0) begin
      if (bits == 8) op = acc;
      else if (bits <= 32) addr = {addr[15:0], acc};
      else begin
        // wrap inside the page, later bytes overwrite earlier ones
        pg[8'(addr[7:0] + nb)] = acc;
        nb++;
        ev_sum ^= acc;
      end
    end
  end

  // status answered even mid cycle so the host can poll
  always @(negedge sck) if (!cs_n && op == 8'h05 && bits >= 8) begin
    so_en = 1'b1;
    so = 8'({wr_latch, in_prog}) >> (7 - bits % 8);
  end

  always @(posedge cs_n) begin
    so_en = 1'b0;
    if (op == 8'h06 && bits == 8) wr_latch = 1'b1;
    else if (op == 8'h05 && in_prog) busy_polls++;
    else if (wr_latch && !in_prog && !PROT) begin
      if ((op == 8'h02 || op == 8'h32 || op == 8'hF2) && bits >= 40 && bits % 8 == 0)
        start(PROG_NS);
      else if ((op == 8'h20 || op == 8'h52 || op == 8'hD8) && bits == 32)
        start(ERASE_NS);
    end
  end

  task automatic start(input int t);
    ev_op = op;
    ev_addr = addr;
    ev_n = 9'(nb);
    ev_cnt++;
    in_prog = 1'b1;
    fork
      begin
        #(t);
        wr_latch = 1'b0;
        in_prog = 1'b0;
      end
    join_none
  endtask
endmodule

/* testbench/serial_flash_program_erase_bench.sv */
`timescale 1ns/1ns

module serial_flash_program_erase_bench;
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [8:0]  n;
    logic [7:0]  sum;
  } sfpe_exp_t;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        cs_n;
  logic        sck;
  logic [3:0]  lo;
  logic [3:0]  oe_n;
  logic [3:0]  wire_l;
  logic        so;
  logic        so_en;
  logic [7:0]  ev_op;
  logic [23:0] ev_addr;
  logic [8:0]  ev_n;
  logic [7:0]  ev_sum;
  logic [7:0]  ev_cnt;
  logic [7:0]  busy_polls;
  logic [7:0]  opc [8] = '{8'h06, 8'h02, 8'h32, 8'hF2, 8'h20, 8'h52, 8'hD8, 8'h05};
  sfpe_exp_t   exp_q [$];
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] r;

  // every line has a pull-up; line1 may be driven by the device
  always_comb for (int i = 0; i < 4; i++)
    wire_l[i] = !oe_n[i] ? lo[i] : ((i == 1 && so_en) ? so : 1'b1);

  initial begin
    forever #5 clk = ~clk;
  end

  sfpe_top u_dut (
    .CLK(clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(), .CS_N(cs_n), .SCK(sck),
    .DATA_LINE_I(wire_l), .DATA_LINE_O(lo), .DATA_LINE_OE_N(oe_n)
  );

  sfpe_flash_model u_flash (
    .cs_n(cs_n), .sck(sck), .lines(wire_l), .so(so), .so_en(so_en), .ev_op(ev_op),
    .ev_addr(ev_addr), .ev_n(ev_n), .ev_sum(ev_sum), .ev_cnt(ev_cnt),
    .busy_polls(busy_polls)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wait_idle(output logic [31:0] q);
    repeat (2) @(posedge clk);
    for (int k = 0; k < 20000; k++) begin
      bus(1'b0, 8'h10, 32'h0, q);
      if (q[0] === 1'b0) break;
    end
  endtask

  task automatic run_op(input logic [2:0] op, input int n, input logic [23:0] a);
    sfpe_exp_t   e;
    logic [7:0]  b;
    logic [7:0]  pb;
    e = '{opc[op], a, 9'(n), 8'h00};
    bus(1'b1, 8'h04, {8'h0, a}, r);
    bus(1'b1, 8'h08, 32'(n), r);
    for (int k = 0; k < n; k++) begin
      b = 8'($urandom);
      e.sum ^= b;
      bus(1'b1, 8'h0C, {24'h0, b}, r);
    end
    exp_q.push_back(e);
    pb = busy_polls;
    bus(1'b1, 8'h00, {29'h0, op}, r);
    wait_idle(r);
    chk("status after op", r[3:0], 4'h0);
    chk("polled while busy", busy_polls != pb, 1);
  endtask

  // the model reports each executed operation; compare with the oldest note
  initial forever begin
    sfpe_exp_t e;
    // the model's start-up value of the counter is not an operation
    wait (reset_n === 1'b1);
    @(ev_cnt);
    if (exp_q.size() == 0) chk("unexpected op", ev_op, 8'h00);
    else begin
      e = exp_q.pop_front();
      chk("opcode", ev_op, e.op);
      chk("address", ev_addr, e.addr);
      chk("byte count", ev_n, e.n);
      chk("data sum", ev_sum, e.sum);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(59));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 8'h10, 32'h0, r);
    chk("status reset", r, 32'h0);
    bus(1'b0, 8'h14, 32'h0, r);
    chk("config reset", r, 32'h0);
    bus(1'b0, 8'h20, 32'h0, r);
    chk("unmapped", r, 32'h0);
    bus(1'b1, 8'h14, 32'h2, r);
    // quad with quad enable clear, then a zero length program
    bus(1'b1, 8'h08, 32'h1, r);
    bus(1'b1, 8'h0C, 32'hA5, r);
    bus(1'b1, 8'h00, 32'h2, r);
    wait_idle(r);
    chk("quad refused", r[1:0], 2'h2);
    bus(1'b1, 8'h08, 32'h0, r);
    bus(1'b1, 8'h00, 32'h1, r);
    wait_idle(r);
    chk("empty refused", r[1:0], 2'h2);
    // write enable alone, then a status read shows the latch
    bus(1'b1, 8'h00, 32'h0, r);
    wait_idle(r);
    bus(1'b1, 8'h00, 32'h7, r);
    wait_idle(r);
    chk("latch seen", r[15:0], 16'h0208);
    bus(1'b1, 8'h14, 32'h3, r);
    run_op(3'h1, 256, {16'($urandom), 8'h9C});
    run_op(3'h2, 1 + $urandom % 16, 24'($urandom));
    run_op(3'h3, 1 + $urandom % 16, 24'($urandom));
    for (int o = 4; o < 7; o++) run_op(3'(o), 0, 24'($urandom));
    repeat (4) @(posedge clk);
    chk("pending ops", exp_q.size(), 0);
    finish_test();
  end
endmodule
